//--- src/sasq_pkg.sv
package sasq_pkg;

  // ************************************************************
  // word and field layout
  // ************************************************************
  localparam int SASQ_WORD_W = 16;
  localparam int SASQ_RES_W = 12;
  localparam int SASQ_RAW_W = 14;
  localparam int SASQ_SEL_BIT = 15;
  localparam int SASQ_CFG_SEL_MSB = 14;
  localparam int SASQ_CFG_SEL_LSB = 11;
  localparam int SASQ_REF_DIFF_BIT = 10;
  localparam int SASQ_ECHO_BIT = 2;
  localparam int SASQ_PAIR_MSB = 10;
  localparam int SASQ_PAIR_LSB = 3;
  localparam int SASQ_PDIFF_BIT = 2;

  localparam logic [3:0] SASQ_SEL_ADC_CFG = 4'h0;
  localparam logic [3:0] SASQ_SEL_UNIPOLAR = 4'h1;
  localparam logic [3:0] SASQ_SEL_BIPOLAR = 4'h2;

  localparam logic [3:0] SASQ_SCAN_MANUAL = 4'h1;
  localparam logic [3:0] SASQ_LAST_PDIFF_CH = 4'he;
  localparam logic [1:0] SASQ_SRST_ALL = 2'h2;
  localparam logic [1:0] SASQ_SRST_FIFO = 2'h1;

  localparam logic [14:0] SASQ_MODE_RST = 15'h0800;
  localparam int SASQ_FIFO_DEPTH = 16;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SASQ_CLK_PERIOD_NS = 10;
  localparam int SASQ_OSC_PERIOD_NS = 25;
  localparam int SASQ_OSC_CLKS_PER_CONV = 16;
  localparam int SASQ_WAKE_NS = 200;
  localparam int SASQ_SOFTWARE_CONVERT_DELAY_NS = 100;
  localparam int SASQ_CONV_CYC =
    (SASQ_OSC_PERIOD_NS * SASQ_OSC_CLKS_PER_CONV + SASQ_CLK_PERIOD_NS - 1) / SASQ_CLK_PERIOD_NS;
  localparam int SASQ_WAKE_CYC = (SASQ_WAKE_NS + SASQ_CLK_PERIOD_NS - 1) / SASQ_CLK_PERIOD_NS;
  localparam int SASQ_SOFTWARE_CONVERT_CYC =
    (SASQ_SOFTWARE_CONVERT_DELAY_NS + SASQ_CLK_PERIOD_NS - 1) / SASQ_CLK_PERIOD_NS;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] chsel;
    logic [1:0] soft_rst;
    logic [1:0] pwr;
    logic channel_tag_enable;
    logic software_convert;
    logic spare;
  } sasq_mode_t;

  typedef struct packed {
    logic [3:0] ch;
    logic [SASQ_RES_W-1:0] code;
  } sasq_result_t;

  typedef enum logic [1:0] {
    SASQ_IDLE,
    SASQ_DELAY,
    SASQ_WAKE,
    SASQ_CONV
  } sasq_state_t;

endpackage

//--- src/sasq_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module sasq_fifo
  import sasq_pkg::*;
#(
  parameter int W = 16,
  parameter int DEPTH = SASQ_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  output logic [W-1:0] o_head,
  output logic o_empty,
  output logic o_full
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [AW-1:0] IDX_LAST = AW'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic pop_ok;
  logic drop_oldest;

  assign o_empty = (cnt_q == '0);
  assign o_full = (cnt_q == CNT_FULL);
  assign o_head = mem_q[rd_q];
  assign pop_ok = i_pop && !o_empty;
  // a push into a full store discards the oldest entry
  assign drop_oldest = i_push && o_full;

  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_clear) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (i_push) begin
        wr_q <= (wr_q == IDX_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop_ok || drop_oldest) begin
        rd_q <= (rd_q == IDX_LAST) ? '0 : rd_q + 1'b1;
      end
      if (i_push && !pop_ok && !o_full) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop_ok && !i_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- src/sasq_top.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1 - host clocks at most 48MHz, mode 1,1
// R2 - data in on rise, out on fall
// R3 - chip select fall samples, starts frame
// R4 - tag on: channel nibble then 12-bit result
// R5 - tag off: zero, result, three zeros
// R6 - 10-bit variant zeroes two result LSBs
// R7 - host holds clock high before select falls
// R8 - unipolar negative input gives code zero
// R9 - single-ended channels always unipolar
// R10 - pseudo-differential converts 15 inputs vs shared
// R11 - binary unipolar, two's complement bipolar
// R12 - differential reference saturates at end codes
// R13 - 16 results, newest overwrites oldest
// R14 - two bytes each, oldest byte first
// R15 - empty store shifts out zeros
// R16 - external: sample, convert, return next frame
// R17 - internal conversions paced by 40MHz oscillator
// R18 - start pulse wakes, scans, stores, shuts down
// R19 - done low at completion until select/start
// R20 - host waits for done before next access
// R21 - software convert starts after select rise
// R22 - host soft-resets switching to external
// R23 - bit 15 chooses mode or config target
// R24 - read position advances per sent byte
// R25 - echo returns written config next frame
module sasq_top
  import sasq_pkg::*;
#(
  parameter int RES_BITS = 12,
  parameter int NUM_CH = 16
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_DIN,
  input wire logic I_CONV_START_N,
  input wire logic signed [SASQ_RAW_W-1:0] I_CONV_RAW,
  output logic O_DOUT,
  output logic O_DOUT_OE,
  output logic O_DONE_N,
  output logic O_SAMPLE,
  output logic [3:0] O_MUX_CH,
  output logic O_MUX_DIFF,
  output logic O_MUX_NEG_SHARED,
  output logic O_BUSY,
  output logic O_FIFO_EMPTY
);

  // ************************************************************
  // pin synchronisers and edge detect
  // ************************************************************
  localparam int P_SCLK = 0;
  localparam int P_CS = 1;
  localparam int P_DIN = 2;
  localparam int P_START = 3;
  localparam logic [3:0] PIN_IDLE = 4'hb;
  localparam logic [11:0] LSB_MASK = (RES_BITS == 10) ? 12'hffc : 12'hfff;
  localparam logic [3:0] CH_MAX = 4'(NUM_CH - 1);

  logic [3:0] pin_raw;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;

  assign pin_raw = {I_CONV_START_N, I_DIN, I_CS_N, I_SCLK};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
          meta_q[gi] <= PIN_IDLE[gi];
          sync_q[gi] <= PIN_IDLE[gi];
          prev_q[gi] <= PIN_IDLE[gi];
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic st_fall;
  logic st_rise;

  assign cs_low = !sync_q[P_CS];
  assign cs_fall = !sync_q[P_CS] && prev_q[P_CS];
  assign cs_rise = sync_q[P_CS] && !prev_q[P_CS];
  assign sclk_rise = cs_low && sync_q[P_SCLK] && !prev_q[P_SCLK]; // R2
  assign sclk_fall = cs_low && !sync_q[P_SCLK] && prev_q[P_SCLK]; // R2
  assign st_fall = !sync_q[P_START] && prev_q[P_START];
  assign st_rise = sync_q[P_START] && !prev_q[P_START];

  // ************************************************************
  // result coding
  // ************************************************************
  function automatic logic [11:0] fmt_code(input logic signed [SASQ_RAW_W-1:0] raw,
                                           input logic bip, input logic sat);
    logic [11:0] c;
    c = raw[11:0];
    if (!bip) begin
      if (raw < 0) begin
        c = 12'h000; // R8
      end else if (sat && raw > 14'sh0fff) begin
        c = 12'hfff; // R12
      end
    end else if (sat) begin
      if (raw > 14'sh07ff) begin
        c = 12'h7ff; // R12
      end else if (raw < -14'sh0800) begin
        c = 12'h800; // R12
      end
    end
    return c & LSB_MASK; // R6 R11
  endfunction

  // ************************************************************
  // configuration state
  // ************************************************************
  sasq_mode_t mode_q;
  logic ref_diff_select_q;
  logic echo_en_q;
  logic pseudo_diff_common_q;
  logic [7:0] uni_pair_q;
  logic [7:0] bip_pair_q;
  logic echo_pend_q;
  logic [15:0] echo_word_q;

  logic [4:0] bit_cnt_q;
  logic [15:0] rx_q;
  logic word_done;
  logic [15:0] word;
  sasq_mode_t wr_mode;
  logic mode_wr;
  logic cfg_wr;
  logic [3:0] cfg_sel;
  logic soft_all;
  logic fifo_clear;
  logic scan_finish;
  logic int_mode;

  assign word_done = sclk_rise && (bit_cnt_q == 5'h0f);
  assign word = {rx_q[14:0], sync_q[P_DIN]};
  assign wr_mode = sasq_mode_t'(word[14:0]);
  assign mode_wr = word_done && !word[SASQ_SEL_BIT]; // R23
  assign cfg_wr = word_done && word[SASQ_SEL_BIT]; // R23
  assign cfg_sel = word[SASQ_CFG_SEL_MSB:SASQ_CFG_SEL_LSB];
  assign soft_all = mode_wr && (wr_mode.soft_rst == SASQ_SRST_ALL);
  assign fifo_clear = soft_all || (mode_wr && wr_mode.soft_rst == SASQ_SRST_FIFO);
  assign int_mode = (mode_q.scan != SASQ_SCAN_MANUAL);

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      bit_cnt_q <= 5'h00;
      rx_q <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise && bit_cnt_q != 5'h10) begin
      rx_q <= word;
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B || soft_all) begin
      mode_q <= sasq_mode_t'(SASQ_MODE_RST);
    end else begin
      if (scan_finish) begin
        mode_q.software_convert <= 1'b0; // R21
      end
      if (mode_wr) begin
        mode_q <= wr_mode;
        mode_q.soft_rst <= 2'h0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B || soft_all) begin
      ref_diff_select_q <= 1'b0;
      echo_en_q <= 1'b0;
      pseudo_diff_common_q <= 1'b0;
      uni_pair_q <= 8'h00;
      bip_pair_q <= 8'h00;
    end else if (cfg_wr) begin
      if (cfg_sel == SASQ_SEL_ADC_CFG) begin
        ref_diff_select_q <= word[SASQ_REF_DIFF_BIT];
        echo_en_q <= word[SASQ_ECHO_BIT];
      end else if (cfg_sel == SASQ_SEL_UNIPOLAR) begin
        uni_pair_q <= word[SASQ_PAIR_MSB:SASQ_PAIR_LSB];
        pseudo_diff_common_q <= word[SASQ_PDIFF_BIT]; // R10
      end else if (cfg_sel == SASQ_SEL_BIPOLAR) begin
        bip_pair_q <= word[SASQ_PAIR_MSB:SASQ_PAIR_LSB];
      end
    end
  end

  // echo of a configuration write in the next frame
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      echo_pend_q <= 1'b0;
      echo_word_q <= 16'h0000;
    end else if (cfg_wr && (echo_en_q ||
                            (cfg_sel == SASQ_SEL_ADC_CFG && word[SASQ_ECHO_BIT]))) begin
      echo_pend_q <= 1'b1; // R25
      echo_word_q <= word; // R25
    end else if (cs_fall) begin
      echo_pend_q <= 1'b0;
    end
  end

  // ************************************************************
  // channel attributes
  // ************************************************************
  sasq_state_t state_q;
  logic [3:0] scan_ch_q;
  logic [3:0] mux_ch;
  logic ch_bip;
  logic ch_diff;

  assign mux_ch = (state_q == SASQ_IDLE) ? mode_q.chsel : scan_ch_q;
  assign ch_diff = !pseudo_diff_common_q && (uni_pair_q[mux_ch[3:1]] || bip_pair_q[mux_ch[3:1]]);
  // single-ended and pseudo-differential inputs are coded unipolar
  assign ch_bip = ch_diff && bip_pair_q[mux_ch[3:1]]; // R9

  assign O_MUX_CH = mux_ch;
  assign O_MUX_DIFF = ch_diff;
  assign O_MUX_NEG_SHARED = pseudo_diff_common_q; // R10

  // ************************************************************
  // external clock sampling
  // ************************************************************
  sasq_result_t ext_res_q;
  sasq_result_t new_res;

  assign new_res = '{ch: mux_ch, code: fmt_code(I_CONV_RAW, ch_bip, ref_diff_select_q)};

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      ext_res_q <= '0;
    end else if (cs_fall && !int_mode) begin
      ext_res_q <= new_res; // R3 R16
    end
  end

  // ************************************************************
  // internal scan sequencer
  // ************************************************************
  logic [15:0] cnt_q;
  logic arm_q;
  logic fifo_push;
  logic fifo_pop;
  sasq_result_t fifo_head;
  logic fifo_empty;
  logic [3:0] last_ch;
  logic conv_end;
  logic sample_q;

  assign last_ch = (pseudo_diff_common_q && mode_q.chsel > SASQ_LAST_PDIFF_CH) ?
                   SASQ_LAST_PDIFF_CH : mode_q.chsel; // R10
  assign conv_end = (state_q == SASQ_CONV) && (cnt_q == 16'(SASQ_CONV_CYC - 1)); // R17
  assign fifo_push = conv_end; // R18
  assign scan_finish = conv_end && (scan_ch_q == last_ch || scan_ch_q == CH_MAX);

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      arm_q <= 1'b0;
    end else if (st_fall && !cs_low) begin
      arm_q <= 1'b1;
    end else if (st_rise || cs_fall) begin
      arm_q <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B || soft_all) begin
      state_q <= SASQ_IDLE;
      cnt_q <= 16'h0000;
      scan_ch_q <= 4'h0;
      sample_q <= 1'b0;
    end else begin
      sample_q <= 1'b0;
      cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        SASQ_IDLE: begin
          cnt_q <= 16'h0000;
          if (int_mode && st_rise && arm_q && !cs_low) begin
            state_q <= SASQ_WAKE; // R18
          end else if (int_mode && cs_rise && mode_q.software_convert) begin
            state_q <= SASQ_DELAY; // R21
          end
        end
        SASQ_DELAY: begin
          if (cnt_q == 16'(SASQ_SOFTWARE_CONVERT_CYC - 1)) begin
            state_q <= SASQ_WAKE; // R21
            cnt_q <= 16'h0000;
          end
        end
        SASQ_WAKE: begin
          if (cnt_q == 16'(SASQ_WAKE_CYC - 1)) begin
            state_q <= SASQ_CONV;
            cnt_q <= 16'h0000;
            scan_ch_q <= 4'h0;
            sample_q <= 1'b1;
          end
        end
        SASQ_CONV: begin
          if (conv_end) begin
            cnt_q <= 16'h0000;
            if (scan_finish) begin
              state_q <= SASQ_IDLE; // R18
            end else begin
              scan_ch_q <= scan_ch_q + 4'h1;
              sample_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= SASQ_IDLE;
        end
      endcase
    end
  end

  // done is set on completion even if a falling edge lands together
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      O_DONE_N <= 1'b1;
    end else if (scan_finish) begin
      O_DONE_N <= 1'b0; // R19
    end else if (cs_fall || st_fall) begin
      O_DONE_N <= 1'b1; // R19
    end
  end

  assign O_SAMPLE = sample_q || (cs_fall && !int_mode);
  assign O_BUSY = (state_q != SASQ_IDLE);
  assign O_FIFO_EMPTY = fifo_empty;

  sasq_fifo #(
    .W(SASQ_WORD_W),
    .DEPTH(SASQ_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_clear(fifo_clear),
    .i_push(fifo_push),
    .i_data(new_res),
    .i_pop(fifo_pop),
    .o_head(fifo_head),
    .o_empty(fifo_empty),
    .o_full()
  ); // R13

  // ************************************************************
  // serial output
  // ************************************************************
  logic [15:0] tx_q;
  logic fifo_tx_q;
  logic byte_sel_q;
  logic [2:0] byte_bits_q;
  logic reload_q;
  logic [7:0] head_byte;
  logic byte_out;

  // byte zero carries the channel ahead of the result msbs
  assign head_byte = fifo_empty ? 8'h00 :
                     (byte_sel_q ? fifo_head.code[7:0] : {fifo_head.ch, fifo_head.code[11:8]});
  assign byte_out = sclk_fall && fifo_tx_q && (byte_bits_q == 3'h7);
  assign fifo_pop = byte_out && byte_sel_q && !fifo_empty; // R24

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B || fifo_clear) begin
      byte_sel_q <= 1'b0;
    end else if (byte_out && !fifo_empty) begin
      byte_sel_q <= !byte_sel_q; // R24
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_B) begin
      tx_q <= 16'h0000;
      fifo_tx_q <= 1'b0;
      byte_bits_q <= 3'h0;
      reload_q <= 1'b0;
      O_DOUT <= 1'b0;
    end else begin
      reload_q <= byte_out;
      if (cs_fall) begin
        byte_bits_q <= 3'h0;
        fifo_tx_q <= !echo_pend_q && int_mode;
        O_DOUT <= 1'b0;
        if (echo_pend_q) begin
          tx_q <= echo_word_q; // R25
        end else if (int_mode) begin
          tx_q <= {head_byte, 8'h00}; // R14 R15
        end else if (mode_q.channel_tag_enable) begin
          tx_q <= {ext_res_q.ch, ext_res_q.code}; // R4 R16
        end else begin
          tx_q <= {1'b0, ext_res_q.code, 3'b000}; // R5
        end
      end else if (sclk_fall) begin
        O_DOUT <= tx_q[15]; // R2
        tx_q <= {tx_q[14:0], 1'b0};
        if (fifo_tx_q) begin
          byte_bits_q <= byte_bits_q + 3'h1;
        end
      end else if (reload_q && fifo_tx_q) begin
        tx_q <= {head_byte, 8'h00}; // R14 R15
      end
    end
  end

  assign O_DOUT_OE = cs_low;

endmodule

`default_nettype wire

//--- test/sasq_properties.sv
`timescale 1ns/100ps
`default_nettype none

module sasq_properties (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_CONV_START_N,
  input wire logic O_DOUT,
  input wire logic O_DOUT_OE,
  input wire logic O_DONE_N,
  input wire logic O_SAMPLE,
  input wire logic O_BUSY,
  input wire logic O_FIFO_EMPTY
);
  // ************************************************************
  // port checks
  // ************************************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);

  a_oe_off_idle: assert property (
    I_CS_N [*4] |-> !O_DOUT_OE) else $error("drive enable on while deselected");
  a_oe_on_select: assert property (
    !I_CS_N [*4] |-> O_DOUT_OE) else $error("drive enable off while selected");
  a_dout_hold_high: assert property (
    !I_CS_N [*6] ##0 I_SCLK [*4] |-> $stable(O_DOUT)) else $error("output moved with clock high");
  a_sample_from_select: assert property (
    O_SAMPLE && !O_BUSY |-> !I_CS_N && ($past(I_CS_N, 3) || $past(I_CS_N, 4) || $past(I_CS_N, 5)))
    else $error("sample without select fall");
  a_done_holds: assert property (
    (I_CS_N && I_CONV_START_N) [*5] ##0 !O_DONE_N |=> !O_DONE_N) else $error("done released early");
  a_done_has_data: assert property (
    $fell(O_DONE_N) |-> !O_FIFO_EMPTY) else $error("done with empty store");
  a_done_ends_scan: assert property (
    $fell(O_DONE_N) |-> $fell(O_BUSY)) else $error("done not at scan end");
  a_done_released: assert property (
    $fell(I_CS_N) && !O_DONE_N |-> ##[2:5] O_DONE_N) else $error("done not released by select");
  a_conv_pace: assert property (
    O_SAMPLE && O_BUSY |-> ##[38:42] (O_SAMPLE || !O_BUSY)) else $error("conversion pace wrong");
  a_wake_first: assert property (
    $rose(O_BUSY) |-> !O_SAMPLE [*8]) else $error("sample before wake");
endmodule

bind sasq_top sasq_properties u_sasq_properties (
  .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N),
  .I_CONV_START_N(I_CONV_START_N), .O_DOUT(O_DOUT), .O_DOUT_OE(O_DOUT_OE),
  .O_DONE_N(O_DONE_N), .O_SAMPLE(O_SAMPLE), .O_BUSY(O_BUSY), .O_FIFO_EMPTY(O_FIFO_EMPTY)
);

`default_nettype wire

//--- test/sasq_host.sv
`timescale 1ns/100ps
`default_nettype none

module sasq_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout
);
  // ************************************************************
  // serial master, clock idles high, 125ns period
  // ************************************************************
  localparam realtime HALF = 62.5;

  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end

  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    o_cs_n = 1'b0;
    #(HALF);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din = tx[i];
      #(HALF);
      o_sclk = 1'b1;
      rx[i] = i_dout;
      #(HALF);
    end
    #(2 * HALF);
    o_cs_n = 1'b1;
    o_din = ~o_din;
    #(4 * HALF);
  endtask
endmodule

`default_nettype wire

//--- test/sasq_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module sasq_top_tb;
  import sasq_pkg::*;
  // ************************************************************
  // bench
  // ************************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start_n = 1'b1;
  logic signed [SASQ_RAW_W-1:0] raw = '0;
  logic bip = 1'b0;
  logic sat = 1'b0;
  logic [15:0] rx;
  logic [15:0] iw;
  logic [11:0] rc [2];
  int num_errors = 0;
  int total_checks = 0;
  wire logic sclk, cs_n, din, dout, oe, done_n, nshr, busy, empty, mux_diff;
  wire logic [3:0] mux_ch;

  always #(SASQ_CLK_PERIOD_NS / 2.0) clk = ~clk;

  sasq_top u_sasq_top (
    .I_MCLK(clk), .I_RST_B(rst_b), .I_SCLK(sclk), .I_CS_N(cs_n), .I_DIN(din),
    .I_CONV_START_N(start_n), .I_CONV_RAW(raw), .O_DOUT(dout), .O_DOUT_OE(oe),
    .O_DONE_N(done_n), .O_SAMPLE(), .O_MUX_CH(mux_ch), .O_MUX_DIFF(mux_diff),
    .O_MUX_NEG_SHARED(nshr), .O_BUSY(busy), .O_FIFO_EMPTY(empty)
  );
  sasq_host u_sasq_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));

  function automatic logic [15:0] mode_w(logic [3:0] scan, logic [3:0] ch, logic [1:0] rst,
                                         logic tag, logic sw);
    return {1'b0, scan, ch, rst, 2'b00, tag, sw, 1'b0};
  endfunction

  function automatic logic [11:0] exp_code(logic signed [SASQ_RAW_W-1:0] r);
    if (sat && r > (bip ? 2047 : 4095)) return bip ? 12'h7ff : 12'hfff;
    if (sat && bip && r < -2048) return 12'h800;
    if (!bip && r < 0) return 12'h000;
    return r[11:0];
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic scan_wait();
    for (int k = 0; k < 2000 && done_n !== 1'b0; k++) @(negedge clk);
    check(16'(done_n), 16'h0, "scan done");
  endtask

  task automatic ext_run(input int span, input int off);
    logic [3:0] ch_n, ch_e, ch_s;
    logic tag_n, tag_e;
    logic [11:0] code_s;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      raw = (i == 4) ? -14'sd1 : 14'($urandom_range(span) - off);
      ch_n = 4'($urandom);
      tag_n = 1'($urandom);
      u_sasq_host.frame(mode_w(SASQ_SCAN_MANUAL, ch_n, 2'h0, tag_n, 1'b0), rx);
      if (i > 1) check(rx, tag_e ? {ch_s, code_s} : {1'b0, code_s, 3'b000}, "result");
      check(16'(mux_ch), 16'(ch_n), "mux channel");
      check(16'(mux_diff), 16'(bip), "pair mode");
      ch_s = ch_e;
      code_s = exp_code(raw);
      ch_e = ch_n;
      tag_e = tag_n;
    end
    $display("test external span %0d done", span);
  endtask

  initial begin
    #(400_000);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(32'h948d));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check({12'h0, done_n, busy, empty, oe}, 16'ha, "reset state");
    u_sasq_host.frame({1'b1, SASQ_SEL_UNIPOLAR, 8'h00, 1'b1, 2'b00}, rx);
    check(16'(nshr), 16'h1, "shared negative");
    iw = mode_w(4'h2, 4'hf, 2'h0, 1'b1, 1'b0);
    u_sasq_host.frame(iw, rx);
    for (int s = 0; s < 2; s++) begin
      @(negedge clk);
      rc[s] = 12'($urandom);
      raw = {2'b00, rc[s]};
      start_n = 1'b0;
      repeat (5) @(negedge clk);
      start_n = 1'b1;
      scan_wait();
    end
    for (int k = 0; k < 17; k++) begin
      u_sasq_host.frame(iw, rx);
      check(rx, k == 0 ? {4'he, rc[0]} : k < 16 ? {4'(k - 1), rc[1]} : 16'h0, "store");
    end
    check({14'h0, empty, done_n}, 16'h3, "drained");
    $display("test start pin scans done");
    @(negedge clk);
    raw = {2'b00, rc[0]};
    u_sasq_host.frame(mode_w(4'h2, 4'h1, 2'h0, 1'b1, 1'b1), rx);
    scan_wait();
    for (int k = 0; k < 2; k++) begin
      u_sasq_host.frame(iw, rx);
      check(rx, {4'(k), rc[0]}, "software scan");
    end
    $display("test software convert done");
    u_sasq_host.frame(mode_w(4'h2, 4'h0, SASQ_SRST_ALL, 1'b0, 1'b0), rx);
    check({14'h0, empty, nshr}, 16'h2, "soft reset");
    ext_run(8191, 4096);
    bip = 1'b1;
    u_sasq_host.frame({1'b1, SASQ_SEL_BIPOLAR, 8'hff, 3'b000}, rx);
    ext_run(4095, 2048);
    sat = 1'b1;
    iw = {1'b1, SASQ_SEL_ADC_CFG, 1'b1, 7'h00, 1'b1, 2'b00};
    u_sasq_host.frame(iw, rx);
    u_sasq_host.frame(mode_w(SASQ_SCAN_MANUAL, 4'h0, 2'h0, 1'b1, 1'b0), rx);
    check(rx, iw, "config echo");
    $display("test config echo done");
    ext_run(16383, 0);
    summarize();
  end
endmodule

`default_nettype wire
